// [perf_ctl_pkg.sv]
// Constants, register map and field layout of the performance counter control block
// Summary of operation
// - A counter counts only when global enable and its privilege enable for the current mode are both set.
// - Global status holds one overflow bit per counter; 1 means that counter overflowed.
// - Global status has a separate bit for overflow of precise sampling counters.
// - Global status has a sticky bit set whenever monitoring hardware state changes.
// - Overflow of a precise counter arms sampling; next counted event makes a sample.
// - Sample passes bounds check: store record, clear counter overflow, reload counter.
// - Sample fails bounds check: no record, reload or overflow clear, but the counter is still disarmed.
// - When the sample buffer becomes full, the buffer-full status bit is set.
// - One write to the overflow clear register clears selected general and fixed flags.
// - Eight general counters exist; the feature query reports 4 or 8.
// - A shared core shows each logical processor only counters zero to three.
// - Unshared core shows all eight; counters four to seven start at address c5.
// - With four reported, counters 4-7 or ones written to bits 7:4 of global status, enable or clear raise a fault.
// - A normal general counter write stores the 32-bit value sign-extended to full width; fixed counter writes load full width.
// - Each general counter has an alias address that loads the full width unextended.
// - Capability bit 13 advertises full-width writes; software tests it before aliasing.
package perf_ctl_pkg;
  localparam int NUM_GP = 8;
  localparam int NUM_FIX = 3;
  localparam int NUM_CTR = NUM_GP + NUM_FIX;
  localparam int NUM_PREC = 4;
  localparam int CTR_W = 48;
  localparam int WR_W = 32;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 32;
  localparam int IDX_W = 16;

  // Register addresses
  localparam logic [31:0] GP_CTR_BASE = 32'h0000_00c1;
  localparam logic [31:0] GP_CTR_FOUR = 32'h0000_00c5;
  localparam logic [31:0] GP_CTR_SEVEN = 32'h0000_00c8;
  localparam logic [31:0] EVSEL_BASE = 32'h0000_0100;
  localparam logic [31:0] FIX_CTR_BASE = 32'h0000_0110;
  localparam logic [31:0] FIX_CTRL_ADDR = 32'h0000_0118;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0120;
  localparam logic [31:0] GLOBAL_EN_ADDR = 32'h0000_0121;
  localparam logic [31:0] CLEAR_ADDR = 32'h0000_0122;
  localparam logic [31:0] CAP_ADDR = 32'h0000_0123;
  localparam logic [31:0] PREC_EN_ADDR = 32'h0000_0124;
  localparam logic [31:0] SAMP_INDEX_ADDR = 32'h0000_0125;
  localparam logic [31:0] SAMP_LIMIT_ADDR = 32'h0000_0126;
  localparam logic [31:0] RELOAD_BASE = 32'h0000_0128;
  localparam logic [31:0] ALIAS_BASE = 32'h0000_0130;

  // Field positions
  localparam int EVSEL_USR_BIT = 16;
  localparam int EVSEL_OS_BIT = 17;
  localparam int EVSEL_EN_BIT = 22;
  localparam int FIX_FIELD_W = 4;
  localparam int FIX_OS_BIT = 0;
  localparam int FIX_USR_BIT = 1;
  localparam int FIX_STAT_LSB = 32;
  localparam int PREC_STAT_BIT = 61;
  localparam int BUF_FULL_BIT = 62;
  localparam int CHANGED_BIT = 63;
  localparam int UPPER_GP_LSB = 4;
  localparam int UPPER_GP_MSB = 7;
  localparam int CAP_FW_BIT = 13;

  // Reset and fixed read values
  localparam logic [63:0] CAP_VALUE = 64'h0000_0000_0000_2000;
  localparam logic [31:0] EVSEL_RESET = 32'h0000_0000;
  localparam logic [IDX_W-1:0] SAMP_RESET = 16'h0000;
  localparam logic [7:0] GP_COUNT_FULL = 8'h08;
  localparam logic [7:0] GP_COUNT_SHARED = 8'h04;
endpackage

// [ctr_if.sv]
// Carrier between the control block and one counter slice
`timescale 1ns/100ps
`default_nettype none
interface ctr_if;
  import perf_ctl_pkg::*;
  logic load;
  logic [CTR_W-1:0] load_val;
  logic inc;
  logic [CTR_W-1:0] value;
  logic ovf;
  modport ctl (output load, output load_val, output inc, input value, input ovf);
  modport cnt (input load, input load_val, input inc, output value, output ovf);
endinterface
`default_nettype wire

// [perf_counter_slice.sv]
// One 48-bit performance counter with load, increment and wrap detection
`timescale 1ns/100ps
`default_nettype none
module perf_counter_slice
  import perf_ctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control side
  ctr_if.cnt cnt
);
  logic [CTR_W-1:0] count_ff;
  logic [CTR_W-1:0] nxt_count;
  wire at_max = &count_ff;

  // A load beats a same-cycle increment, so no overflow is reported then
  assign nxt_count = cnt.load ? cnt.load_val : (cnt.inc ? count_ff + 1'b1 : count_ff);
  assign cnt.value = count_ff;
  assign cnt.ovf = cnt.inc & ~cnt.load & at_max;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  a_load_value: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cnt.load |=> count_ff == $past(cnt.load_val))
    else $error("counter did not take load value");
  a_count_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cnt.inc && !cnt.load |=> count_ff == $past(count_ff) + 48'h1 && (($past(at_max)) == (count_ff == 48'h0)))
    else $error("counter step or wrap wrong");
  a_hold_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !cnt.inc && !cnt.load |=> $stable(count_ff))
    else $error("idle counter moved");
endmodule
`default_nettype wire

// [perf_counter_ctl.sv]
// Global enable, overflow status, clear and precise sampling control of the counters
`timescale 1ns/100ps
`default_nettype none
module perf_counter_ctl
  import perf_ctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register access port
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_fault_o,
  // Events and context
  input wire logic [NUM_GP-1:0] gen_event_i,
  input wire logic [NUM_FIX-1:0] fixed_event_i,
  input wire logic user_mode_i,
  input wire logic core_shared_i,
  // Feature query and sample records
  output logic [7:0] gp_count_o,
  output logic rec_store_o,
  output logic [1:0] rec_ctr_o,
  output logic [IDX_W-1:0] rec_slot_o
);

  function automatic logic in_range(input logic [31:0] addr, input logic [31:0] base, input int n);
    in_range = (addr >= base) && (addr < base + 32'(n));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [NUM_GP-1:0] gen_gp_ff;
  logic [NUM_FIX-1:0] gen_fix_ff;
  logic [31:0] evsel_ff [NUM_GP];
  logic [NUM_FIX*FIX_FIELD_W-1:0] fix_ctrl_ff;
  logic [NUM_PREC-1:0] prec_en_ff;
  logic [CTR_W-1:0] reload_ff [NUM_PREC];
  logic [IDX_W-1:0] samp_index_ff;
  logic [IDX_W-1:0] samp_limit_ff;
  logic [NUM_GP-1:0] gp_ovf_ff;
  logic [NUM_FIX-1:0] fix_ovf_ff;
  logic prec_ovf_ff;
  logic buf_full_ff;
  logic chg_ff;
  logic [NUM_PREC-1:0] armed_ff;
  logic [DATA_W-1:0] rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [31:0] gp_off = reg_addr_i - GP_CTR_BASE;
  wire [31:0] al_off = reg_addr_i - ALIAS_BASE;
  wire [31:0] ev_off = reg_addr_i - EVSEL_BASE;
  wire [31:0] fx_off = reg_addr_i - FIX_CTR_BASE;
  wire [31:0] rl_off = reg_addr_i - RELOAD_BASE;
  wire [2:0] gp_idx = gp_off[2:0];
  wire [2:0] al_idx = al_off[2:0];
  wire [2:0] ev_idx = ev_off[2:0];
  wire [1:0] fx_idx = fx_off[1:0];
  wire [1:0] rl_idx = rl_off[1:0];
  wire gp_hit = in_range(reg_addr_i, GP_CTR_BASE, NUM_GP);
  wire al_hit = in_range(reg_addr_i, ALIAS_BASE, NUM_GP);
  wire ev_hit = in_range(reg_addr_i, EVSEL_BASE, NUM_GP);
  wire fx_hit = in_range(reg_addr_i, FIX_CTR_BASE, NUM_FIX);
  wire rl_hit = in_range(reg_addr_i, RELOAD_BASE, NUM_PREC);
  wire fctl_hit = reg_addr_i == FIX_CTRL_ADDR;
  wire stat_hit = reg_addr_i == STATUS_ADDR;
  wire en_hit = reg_addr_i == GLOBAL_EN_ADDR;
  wire clr_hit = reg_addr_i == CLEAR_ADDR;
  wire cap_hit = reg_addr_i == CAP_ADDR;
  wire pe_hit = reg_addr_i == PREC_EN_ADDR;
  wire idx_hit = reg_addr_i == SAMP_INDEX_ADDR;
  wire lim_hit = reg_addr_i == SAMP_LIMIT_ADDR;
  wire any_hit = gp_hit | al_hit | ev_hit | fx_hit | rl_hit | fctl_hit | stat_hit | en_hit | clr_hit
    | cap_hit | pe_hit | idx_hit | lim_hit;

  // Upper four counters belong to the sibling thread when the core is shared
  wire upper_acc = core_shared_i & ((gp_hit & gp_idx[2]) | (al_hit & al_idx[2]) | (ev_hit & ev_idx[2]));
  wire upper_bits = core_shared_i & reg_wr_i & (en_hit | stat_hit | clr_hit)
    & (|reg_wdata_i[UPPER_GP_MSB:UPPER_GP_LSB]);
  wire fault_c = upper_acc | upper_bits | ~any_hit;
  wire acc_ok = reg_req_i & ~fault_c;
  wire wr_ok = acc_ok & reg_wr_i;
  wire [CTR_W-1:0] sext_val = {{(CTR_W-WR_W){reg_wdata_i[WR_W-1]}}, reg_wdata_i[WR_W-1:0]};
  wire [CTR_W-1:0] full_val = reg_wdata_i[CTR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Counter slices and count gating
  ctr_if cif [NUM_CTR] ();
  logic [CTR_W-1:0] ctr_val [NUM_CTR];
  logic [NUM_CTR-1:0] ctr_inc;
  logic [NUM_CTR-1:0] ctr_ovf;
  logic [NUM_PREC-1:0] prec_load;

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      if (g < NUM_GP) begin : g_gp
        wire priv_ok = user_mode_i ? evsel_ff[g][EVSEL_USR_BIT] : evsel_ff[g][EVSEL_OS_BIT];
        wire wr_this = wr_ok & ((gp_hit & gp_idx == 3'(g)) | (al_hit & al_idx == 3'(g)));
        assign ctr_inc[g] = gen_event_i[g] & gen_gp_ff[g] & evsel_ff[g][EVSEL_EN_BIT] & priv_ok;
        if (g < NUM_PREC) begin : g_prec
          assign cif[g].load = wr_this | prec_load[g];
          assign cif[g].load_val = wr_this ? (al_hit ? full_val : sext_val) : reload_ff[g];
        end else begin : g_plain
          assign cif[g].load = wr_this;
          assign cif[g].load_val = al_hit ? full_val : sext_val;
        end
      end else begin : g_fix
        localparam int F = g - NUM_GP;
        wire priv_ok = user_mode_i ? fix_ctrl_ff[F*FIX_FIELD_W+FIX_USR_BIT] : fix_ctrl_ff[F*FIX_FIELD_W+FIX_OS_BIT];
        assign ctr_inc[g] = fixed_event_i[F] & gen_fix_ff[F] & priv_ok;
        assign cif[g].load = wr_ok & fx_hit & (fx_idx == 2'(F));
        assign cif[g].load_val = full_val;
      end
      assign cif[g].inc = ctr_inc[g];
      assign ctr_val[g] = cif[g].value;
      assign ctr_ovf[g] = cif[g].ovf;
      perf_counter_slice u_slice (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .cnt(cif[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Precise sampling: one sample per cycle, lowest counter first
  logic prec_any;
  logic [1:0] prec_idx;
  always_comb begin
    prec_any = 1'b0;
    prec_idx = 2'h0;
    for (int i = NUM_PREC - 1; i >= 0; i--) begin
      if (armed_ff[i] & ctr_inc[i]) begin
        prec_any = 1'b1;
        prec_idx = 2'(i);
      end
    end
  end

  wire bounds_ok = samp_index_ff < samp_limit_ff;
  wire prec_store = prec_any & bounds_ok;
  wire last_slot = (samp_index_ff + 16'h0001) == samp_limit_ff;
  wire [NUM_PREC-1:0] prec_sel = NUM_PREC'(1) << prec_idx;
  wire [NUM_PREC-1:0] arm_set = ctr_ovf[NUM_PREC-1:0] & prec_en_ff;
  assign prec_load = prec_store ? prec_sel : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Status next values; hardware set wins over a software clear
  wire clr_wr = wr_ok & clr_hit;
  wire [NUM_GP-1:0] clr_gp = clr_wr ? reg_wdata_i[NUM_GP-1:0] : '0;
  wire [NUM_FIX-1:0] clr_fix = clr_wr ? reg_wdata_i[FIX_STAT_LSB+NUM_FIX-1:FIX_STAT_LSB] : '0;
  wire [NUM_GP-1:0] hw_clr_gp = {{(NUM_GP-NUM_PREC){1'b0}}, prec_load};
  wire buf_set = prec_store & last_slot;
  wire prec_set = |arm_set;
  wire [NUM_GP-1:0] nxt_gp_ovf = (gp_ovf_ff & ~clr_gp & ~hw_clr_gp) | ctr_ovf[NUM_GP-1:0];
  wire [NUM_FIX-1:0] nxt_fix_ovf = (fix_ovf_ff & ~clr_fix) | ctr_ovf[NUM_CTR-1:NUM_GP];
  wire nxt_prec_ovf = (prec_ovf_ff & ~(clr_wr & reg_wdata_i[PREC_STAT_BIT])) | prec_set;
  wire nxt_buf_full = (buf_full_ff & ~(clr_wr & reg_wdata_i[BUF_FULL_BIT])) | buf_set;
  wire nxt_chg = (chg_ff & ~(clr_wr & reg_wdata_i[CHANGED_BIT])) | (|ctr_ovf) | buf_set | prec_set;
  wire [NUM_PREC-1:0] nxt_armed = (armed_ff & ~(prec_any ? prec_sel : '0)) | arm_set;
  wire [DATA_W-1:0] status_c = {chg_ff, buf_full_ff, prec_ovf_ff, 26'h0, fix_ovf_ff, 24'h0, gp_ovf_ff};
  wire [DATA_W-1:0] gen_c = {29'h0, gen_fix_ff, 24'h0, gen_gp_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [DATA_W-1:0] nxt_rd;
  always_comb begin
    nxt_rd = '0;
    if (gp_hit) nxt_rd = {16'h0, ctr_val[gp_idx]};
    else if (al_hit) nxt_rd = {16'h0, ctr_val[al_idx]};
    else if (ev_hit) nxt_rd = {32'h0, evsel_ff[ev_idx]};
    else if (fx_hit) nxt_rd = {16'h0, ctr_val[NUM_GP + int'(fx_idx)]};
    else if (rl_hit) nxt_rd = {16'h0, reload_ff[rl_idx]};
    else if (fctl_hit) nxt_rd = {52'h0, fix_ctrl_ff};
    else if (stat_hit) nxt_rd = status_c;
    else if (en_hit) nxt_rd = gen_c;
    else if (cap_hit) nxt_rd = CAP_VALUE;
    else if (pe_hit) nxt_rd = {60'h0, prec_en_ff};
    else if (idx_hit) nxt_rd = {48'h0, samp_index_ff};
    else if (lim_hit) nxt_rd = {48'h0, samp_limit_ff};
    if (!acc_ok || reg_wr_i) nxt_rd = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gen_gp_ff <= '0;
      gen_fix_ff <= '0;
      fix_ctrl_ff <= '0;
      prec_en_ff <= '0;
      samp_limit_ff <= SAMP_RESET;
      for (int i = 0; i < NUM_GP; i++) evsel_ff[i] <= EVSEL_RESET;
      for (int i = 0; i < NUM_PREC; i++) reload_ff[i] <= '0;
    end else if (wr_ok) begin
      if (en_hit) gen_gp_ff <= reg_wdata_i[NUM_GP-1:0];
      if (en_hit) gen_fix_ff <= reg_wdata_i[FIX_STAT_LSB+NUM_FIX-1:FIX_STAT_LSB];
      if (fctl_hit) fix_ctrl_ff <= reg_wdata_i[NUM_FIX*FIX_FIELD_W-1:0];
      if (pe_hit) prec_en_ff <= reg_wdata_i[NUM_PREC-1:0];
      if (lim_hit) samp_limit_ff <= reg_wdata_i[IDX_W-1:0];
      if (ev_hit) evsel_ff[ev_idx] <= reg_wdata_i[31:0];
      if (rl_hit) reload_ff[rl_idx] <= reg_wdata_i[CTR_W-1:0];
    end
  end

  // Status, sampling state and answers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gp_ovf_ff <= '0;
      fix_ovf_ff <= '0;
      prec_ovf_ff <= 1'b0;
      buf_full_ff <= 1'b0;
      chg_ff <= 1'b0;
      armed_ff <= '0;
      samp_index_ff <= SAMP_RESET;
      rd_data_ff <= '0;
      reg_ack_o <= 1'b0;
      reg_fault_o <= 1'b0;
      gp_count_o <= GP_COUNT_FULL;
      rec_store_o <= 1'b0;
      rec_ctr_o <= 2'h0;
      rec_slot_o <= SAMP_RESET;
    end else begin
      gp_ovf_ff <= nxt_gp_ovf;
      fix_ovf_ff <= nxt_fix_ovf;
      prec_ovf_ff <= nxt_prec_ovf;
      buf_full_ff <= nxt_buf_full;
      chg_ff <= nxt_chg;
      armed_ff <= nxt_armed;
      // A software write to the index wins over a same-cycle sample advance
      if (wr_ok && idx_hit) samp_index_ff <= reg_wdata_i[IDX_W-1:0];
      else if (prec_store) samp_index_ff <= samp_index_ff + 16'h0001;
      rd_data_ff <= nxt_rd;
      reg_ack_o <= reg_req_i;
      reg_fault_o <= reg_req_i & fault_c;
      gp_count_o <= core_shared_i ? GP_COUNT_SHARED : GP_COUNT_FULL;
      rec_store_o <= prec_store;
      rec_ctr_o <= prec_idx;
      rec_slot_o <= samp_index_ff;
    end
  end
  assign reg_rdata_o = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_count_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (ctr_inc[NUM_GP-1:0] & ~gen_gp_ff) == '0 && (ctr_inc[NUM_CTR-1:NUM_GP] & ~gen_fix_ff) == '0)
    else $error("counter incremented while globally disabled");
  a_ovf_status: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ctr_ovf[0] |=> gp_ovf_ff[0] && chg_ff && ctr_val[0] == 48'h0)
    else $error("overflow did not set status");
  a_prec_arm: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ctr_ovf[0] && prec_en_ff[0] |=> armed_ff[0] && prec_ovf_ff)
    else $error("precise overflow did not arm");
  a_prec_store: assert property (@(posedge core_clk_i) disable iff (reset_i)
    prec_store && !(wr_ok && idx_hit) |=> rec_store_o && samp_index_ff == $past(samp_index_ff) + 16'h0001
      && !gp_ovf_ff[rec_ctr_o] && !armed_ff[rec_ctr_o])
    else $error("precise sample not stored");
  a_bounds_skip: assert property (@(posedge core_clk_i) disable iff (reset_i)
    prec_any && !bounds_ok && !(wr_ok && idx_hit) |=> !rec_store_o && $stable(samp_index_ff))
    else $error("failed bounds check still stored");
  a_buf_full: assert property (@(posedge core_clk_i) disable iff (reset_i)
    prec_store && last_slot |=> buf_full_ff ##1 buf_full_ff || $past(clr_wr))
    else $error("buffer full flag missing");
  a_clear_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clr_wr && reg_wdata_i[0] && reg_wdata_i[FIX_STAT_LSB] && !ctr_ovf[0] && !ctr_ovf[NUM_GP]
      |=> !gp_ovf_ff[0] && !fix_ovf_ff[0])
    else $error("overflow clear did not clear");
  a_upper_fault: assert property (@(posedge core_clk_i) disable iff (reset_i)
    reg_req_i && core_shared_i && gp_hit && gp_idx[2]
      |=> reg_ack_o && reg_fault_o && ($stable(ctr_val[4]) || $past(ctr_inc[4])))
    else $error("hidden counter access not faulted");
  a_feature_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 gp_count_o == ($past(core_shared_i) ? 8'h04 : 8'h08))
    else $error("feature query count wrong");
  a_sign_extend: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_ok && gp_hit && gp_idx == 3'h0 |=> ctr_val[0] == {{16{$past(reg_wdata_i[31])}}, $past(reg_wdata_i[31:0])})
    else $error("normal write not sign extended");
  a_alias_full: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_ok && al_hit && al_idx == 3'h0 |=> ctr_val[0] == $past(reg_wdata_i[47:0]))
    else $error("alias write not full width");
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the performance counter control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import perf_ctl_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [NUM_GP-1:0] gen_ev = '0;
  logic [NUM_FIX-1:0] fix_ev = '0;
  logic user_mode = 1'b1;
  logic shared = 1'b0;
  logic ack;
  logic fault;
  logic rec_store;
  logic [DATA_W-1:0] rdata;
  logic [7:0] gp_count;
  logic [1:0] rec_ctr;
  logic [IDX_W-1:0] rec_slot;
  logic [1:0] last_ctr = '0;
  logic [IDX_W-1:0] last_slot = '0;
  logic [DATA_W-1:0] rd;
  logic flt;
  int n_fail = 0;
  int checks = 0;
  int n_rec = 0;

  always #4 core_clk = ~core_clk;

  perf_counter_ctl DUT (.core_clk_i(core_clk), .reset_i(reset), .reg_req_i(req), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_ack_o(ack), .reg_rdata_o(rdata), .reg_fault_o(fault),
    .gen_event_i(gen_ev), .fixed_event_i(fix_ev), .user_mode_i(user_mode), .core_shared_i(shared),
    .gp_count_o(gp_count), .rec_store_o(rec_store), .rec_ctr_o(rec_ctr), .rec_slot_o(rec_slot));

  // Record pulses stand one cycle, so they are caught on every edge
  always @(posedge core_clk) begin
    if (rec_store === 1'b1) begin
      n_rec <= n_rec + 1;
      last_ctr <= rec_ctr;
      last_slot <= rec_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request is a one-cycle pulse; the answer is taken at the edge that samples ack high
  task automatic reg_op(input logic w, input logic [31:0] a, input logic [63:0] d);
    int i;
    @(posedge core_clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      if (ack === 1'b1) break;
    end
    if (i == 4) begin
      n_fail++;
      $display("Error ack expected 1 seen 0");
      tally_and_finish();
    end
    rd = rdata;
    flt = fault;
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [63:0] exp);
    reg_op(1'b0, a, '0);
    chk(what, exp, rd);
  endtask

  task automatic pulse(input logic [NUM_GP-1:0] g, input logic [NUM_FIX-1:0] f, input int n);
    @(posedge core_clk);
    gen_ev <= g;
    fix_ev <= f;
    repeat (n) @(posedge core_clk);
    gen_ev <= '0;
    fix_ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("gp_count", 64'h8, {56'h0, gp_count});
    rchk("capability", CAP_ADDR, 64'h0000_0000_0000_2000);
    rchk("status", STATUS_ADDR, 64'h0);
  endtask

  task automatic t_width();
    reg_op(1'b1, GP_CTR_BASE, 64'hffff_ffff_8000_0001);
    rchk("counter0 sext", GP_CTR_BASE, 64'h0000_ffff_8000_0001);
    reg_op(1'b1, ALIAS_BASE, 64'h0000_1234_8000_0001);
    rchk("counter0 alias", GP_CTR_BASE, 64'h0000_1234_8000_0001);
  endtask

  task automatic t_gating();
    reg_op(1'b1, GP_CTR_BASE, 64'h0);
    reg_op(1'b1, FIX_CTR_BASE, 64'h0);
    reg_op(1'b1, EVSEL_BASE, 64'h0000_0000_0041_0000);
    reg_op(1'b1, FIX_CTRL_ADDR, 64'h2);
    reg_op(1'b1, GLOBAL_EN_ADDR, 64'h0000_0001_0000_0001);
    pulse(8'h01, 3'h1, 5);
    rchk("counter0 user", GP_CTR_BASE, 64'h5);
    rchk("fixed0 user", FIX_CTR_BASE, 64'h5);
    // Privilege mismatch must stop both kinds of counter
    user_mode <= 1'b0;
    pulse(8'h01, 3'h1, 3);
    user_mode <= 1'b1;
    rchk("counter0 os", GP_CTR_BASE, 64'h5);
    rchk("fixed0 os", FIX_CTR_BASE, 64'h5);
    reg_op(1'b1, GLOBAL_EN_ADDR, 64'h0);
    pulse(8'h01, 3'h1, 3);
    rchk("counter0 global off", GP_CTR_BASE, 64'h5);
    reg_op(1'b1, GLOBAL_EN_ADDR, 64'h0000_0001_0000_0001);
  endtask

  task automatic t_overflow();
    reg_op(1'b1, ALIAS_BASE, 64'h0000_ffff_ffff_ffff);
    reg_op(1'b1, FIX_CTR_BASE, 64'h0000_ffff_ffff_ffff);
    pulse(8'h01, 3'h1, 1);
    rchk("status ovf", STATUS_ADDR, 64'h8000_0001_0000_0001);
    rchk("counter0 wrap", GP_CTR_BASE, 64'h0);
    reg_op(1'b1, CLEAR_ADDR, 64'h8000_0001_0000_0001);
    rchk("status cleared", STATUS_ADDR, 64'h0);
  endtask

  task automatic t_precise();
    reg_op(1'b1, RELOAD_BASE, 64'h10);
    reg_op(1'b1, PREC_EN_ADDR, 64'h1);
    reg_op(1'b1, SAMP_INDEX_ADDR, 64'h0);
    reg_op(1'b1, SAMP_LIMIT_ADDR, 64'h1);
    reg_op(1'b1, ALIAS_BASE, 64'h0000_ffff_ffff_ffff);
    pulse(8'h01, 3'h0, 1);
    rchk("status armed", STATUS_ADDR, 64'ha000_0000_0000_0001);
    chk("records early", 64'h0, 64'(n_rec));
    pulse(8'h01, 3'h0, 1);
    chk("records", 64'h1, 64'(n_rec));
    chk("record ctr", 64'h0, {62'h0, last_ctr});
    chk("record slot", 64'h0, {48'h0, last_slot});
    rchk("counter0 reload", GP_CTR_BASE, 64'h10);
    reg_op(1'b0, STATUS_ADDR, '0);
    chk("status full", 64'h4000_0000_0000_0000, rd & 64'h4000_0000_0000_00ff);
    // Index now equals limit, so the next sample has to be dropped
    reg_op(1'b1, CLEAR_ADDR, 64'he000_0007_0000_00ff);
    reg_op(1'b1, ALIAS_BASE, 64'h0000_ffff_ffff_ffff);
    pulse(8'h01, 3'h0, 1);
    pulse(8'h01, 3'h0, 1);
    chk("records skipped", 64'h1, 64'(n_rec));
    rchk("counter0 kept", GP_CTR_BASE, 64'h1);
    rchk("sample index", SAMP_INDEX_ADDR, 64'h1);
    reg_op(1'b1, PREC_EN_ADDR, 64'h0);
  endtask

  task automatic t_shared();
    logic [31:0] hidden [4];
    logic [31:0] glob [3];
    hidden = '{GP_CTR_FOUR, GP_CTR_SEVEN, EVSEL_BASE + 32'h4, ALIAS_BASE + 32'h7};
    glob = '{STATUS_ADDR, GLOBAL_EN_ADDR, CLEAR_ADDR};
    shared <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("gp_count shared", 64'h4, {56'h0, gp_count});
    foreach (hidden[k]) begin
      reg_op(1'b0, hidden[k], '0);
      chk("hidden fault", 64'h1, {63'h0, flt});
      chk("hidden rdata", 64'h0, rd);
    end
    foreach (glob[k]) begin
      reg_op(1'b1, glob[k], 64'h10);
      chk("upper bits fault", 64'h1, {63'h0, flt});
    end
    reg_op(1'b0, GP_CTR_BASE + 32'h3, '0);
    chk("counter3 fault", 64'h0, {63'h0, flt});
    shared <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("gp_count full", 64'h8, {56'h0, gp_count});
    reg_op(1'b1, GP_CTR_SEVEN, 64'h0000_0000_0000_0abc);
    chk("counter7 fault", 64'h0, {63'h0, flt});
    rchk("counter7", GP_CTR_SEVEN, 64'h0abc);
    reg_op(1'b1, GLOBAL_EN_ADDR, 64'h10);
    chk("upper bits ok", 64'h0, {63'h0, flt});
    reg_op(1'b0, 32'h0000_0200, '0);
    chk("unmapped fault", 64'h1, {63'h0, flt});
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_width();
    t_gating();
    t_overflow();
    t_precise();
    t_shared();
    tally_and_finish();
  end
endmodule
`default_nettype wire
